// ===== rtl/cdf_bus_if.sv
// Purpose: Two-wire serial bus between the controller and the divider target.
// Assumes: SDA is open drain with a pull-up; SCL is driven push-pull, by the controller alone.
// Notes:   The wire level is resolved here from the drivers and their enables.
`timescale 1ns/1ps
interface cdf_bus_if;
  logic scl;
  logic sda;
  logic sda_host_o;
  logic sda_host_oe;
  logic sda_dev_o;
  logic sda_dev_oe;

  // SDA reads low only while an enabled driver pulls it low.
  assign sda = ~((sda_host_oe & ~sda_host_o) | (sda_dev_oe & ~sda_dev_o));

  modport target (
    input  scl,
    input  sda,
    output sda_dev_o,
    output sda_dev_oe
  );
  modport controller (
    output scl,
    input  sda,
    output sda_host_o,
    output sda_host_oe
  );
endinterface

// ===== rtl/cdf_controller.sv
// Purpose: Bus controller that writes and reads the divider's disable mask on software orders.
// Assumes: Avalon-MM slave with waitrequest; byte addresses; one target on the bus.
// Notes:   Each bus bit takes four quarter ticks; SCL is driven push-pull, no clock stretching.
`timescale 1ns/1ps
module cdf_controller #(
  parameter int QUARTER_CYC = cdf_pkg::SCL_QUARTER_CYC
) (
  // System
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Register bus
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Serial bus
  cdf_bus_if.controller    bus
);
  typedef enum logic [1:0] {H_IDLE, H_START, H_BITS, H_STOP} cdf_host_state_type;
  localparam int CW = $clog2(QUARTER_CYC + 1);

  cdf_host_state_type          st_q, st_d;
  logic [CW-1:0]               cnt_q, cnt_d;
  logic [1:0]                  ph_q, ph_d;
  logic [4:0]                  idx_q, idx_d;
  logic [cdf_pkg::FRAME_BITS-1:0] frame_q, frame_d;
  logic [7:0]                  rx_q, rx_d;
  logic [7:0]                  tx_q, tx_d;
  logic [6:0]                  tgt_q, tgt_d;
  logic                        rw_q, rw_d;
  logic                        nack_q, nack_d;
  logic                        scl_q, scl_d;
  logic                        oe_q, oe_d;
  logic                        ack_q, ack_d;
  logic [31:0]                 rdata_q, rdata_d;
  logic                        s1_q, s2_q;
  logic                        acc;
  logic                        tick;
  logic                        go_rd;

  assign acc             = (avs_read | avs_write) & ~ack_q;
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign avs_readdata    = rdata_q;
  assign tick            = (st_q != H_IDLE) && (cnt_q == CW'(QUARTER_CYC - 1));
  assign go_rd           = avs_writedata[cdf_pkg::CTRL_READ_BIT];
  assign bus.scl         = scl_q;
  assign bus.sda_host_o  = 1'b0;
  assign bus.sda_host_oe = oe_q;

  always_comb begin
    st_d    = st_q;
    cnt_d   = tick ? '0 : ((st_q == H_IDLE) ? '0 : cnt_q + CW'(1));
    ph_d    = tick ? ph_q + 2'h1 : ph_q;
    idx_d   = idx_q;
    frame_d = frame_q;
    rx_d    = rx_q;
    tx_d    = tx_q;
    tgt_d   = tgt_q;
    rw_d    = rw_q;
    nack_d  = nack_q;
    scl_d   = scl_q;
    oe_d    = oe_q;
    ack_d   = acc;
    rdata_d = rdata_q;
    if (acc && avs_write) begin
      unique case (avs_address)
        cdf_pkg::REG_CTRL: begin
          // A start order while busy is dropped.
          if (st_q == H_IDLE && avs_writedata[cdf_pkg::CTRL_GO_BIT]) begin
            st_d    = H_START;
            ph_d    = 2'h0;
            rw_d    = go_rd;
            nack_d  = 1'b0;
            // A read leaves the whole second slot released, ending in NACK.
            frame_d = {tgt_q, go_rd, 1'b1, (go_rd ? 8'hff : tx_q), 1'b1};
          end
        end
        cdf_pkg::REG_TARGET: tgt_d = avs_writedata[6:0];
        cdf_pkg::REG_TXDATA: tx_d = avs_writedata[7:0];
        default: ;
      endcase
    end
    if (acc && avs_read) begin
      unique case (avs_address)
        cdf_pkg::REG_CTRL:   rdata_d = {30'h0, rw_q, 1'b0};
        cdf_pkg::REG_TARGET: rdata_d = {25'h0, tgt_q};
        cdf_pkg::REG_TXDATA: rdata_d = {24'h0, tx_q};
        cdf_pkg::REG_STATUS: rdata_d = {16'h0, rx_q, 6'h0, nack_q, st_q != H_IDLE};
        default:             rdata_d = 32'h0;
      endcase
    end
    if (tick) begin
      unique case (st_q)
        H_START: begin
          unique case (ph_q)
            2'h0: begin
              scl_d = 1'b1;
              oe_d  = 1'b0;
            end
            2'h1: oe_d = 1'b1;
            2'h2: ;
            2'h3: begin
              scl_d = 1'b0;
              st_d  = H_BITS;
              idx_d = 5'h00;
            end
          endcase
        end
        H_BITS: begin
          unique case (ph_q)
            2'h0: oe_d = ~frame_q[cdf_pkg::FRAME_BITS-1];
            2'h1: scl_d = 1'b1;
            2'h2: ;
            2'h3: begin
              scl_d   = 1'b0;
              frame_d = {frame_q[cdf_pkg::FRAME_BITS-2:0], 1'b1};
              if (idx_q > cdf_pkg::ADDR_ACK_IDX && idx_q < cdf_pkg::LAST_IDX) begin
                rx_d = {rx_q[6:0], s2_q};
              end
              if (s2_q && (idx_q == cdf_pkg::ADDR_ACK_IDX ||
                           (idx_q == cdf_pkg::LAST_IDX && rw_q != cdf_pkg::DIR_READ))) begin
                nack_d = 1'b1;
              end
              if (idx_q == cdf_pkg::LAST_IDX || (idx_q == cdf_pkg::ADDR_ACK_IDX && s2_q)) begin
                st_d = H_STOP;
              end else begin
                idx_d = idx_q + 5'h01;
              end
            end
          endcase
        end
        H_STOP: begin
          unique case (ph_q)
            2'h0: oe_d = 1'b1;
            2'h1: scl_d = 1'b1;
            2'h2: oe_d = 1'b0;
            2'h3: st_d = H_IDLE;
          endcase
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q    <= H_IDLE;
      cnt_q   <= '0;
      ph_q    <= 2'h0;
      idx_q   <= 5'h00;
      frame_q <= '1;
      rx_q    <= 8'h00;
      tx_q    <= 8'h00;
      tgt_q   <= 7'h00;
      rw_q    <= 1'b0;
      nack_q  <= 1'b0;
      scl_q   <= 1'b1;
      oe_q    <= 1'b0;
      ack_q   <= 1'b0;
      rdata_q <= 32'h0;
      s1_q    <= 1'b1;
      s2_q    <= 1'b1;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      ph_q    <= ph_d;
      idx_q   <= idx_d;
      frame_q <= frame_d;
      rx_q    <= rx_d;
      tx_q    <= tx_d;
      tgt_q   <= tgt_d;
      rw_q    <= rw_d;
      nack_q  <= nack_d;
      scl_q   <= scl_d;
      oe_q    <= oe_d;
      ack_q   <= ack_d;
      rdata_q <= rdata_d;
      s1_q    <= bus.sda;
      s2_q    <= s1_q;
    end
  end
endmodule

// ===== rtl/cdf_pkg.sv
// Purpose: Shared constants for the clock divider fanout and its serial bus controller.
// Assumes: One 100 MHz system clock in both ends; the bus clock is sampled, not used as a clock.
// Notes:   What this block does, rule by rule:
// What this block does
// - Select 00 or open gives divide by one.
// - Select 01, 10, 11 divide by 2, 4, 8.
// - Selects asynchronous; one ratio for all outputs.
// - Mask bit 0 drives pair, 1 floats it.
// - Mask bit n controls output pair n.
// - Reset clears all mask bits to zero.
// - After a write, register alone sets enables.
// - Register updates ignore the reference clock.
// - Controller avoids re-enabling outputs while live; cdf_controller does not check this, the bench halts the reference first.
// - Target supports standard register write and read.
// - Answer only 11010 plus two strap bits.
// - Address bit 0 selects read or write.
// - Straps differ between targets on one bus.
// - Start and stop are SDA edges, SCL high.
// - SDA changes only while SCL is low.
// - Acknowledger holds SDA low across the clock.
// - Start, address, bytes with acknowledge, then stop.
// - New enables apply within 1 us of stop.
package cdf_pkg;
  localparam int         CLK_FREQ_KHZ       = 100000;
  localparam int         NUM_OUTPUTS        = 8;
  localparam int         SCL_FREQ_KHZ       = 400;
  localparam int         SCL_QUARTER_CYC    = (CLK_FREQ_KHZ + 4 * SCL_FREQ_KHZ - 1) /
                                              (4 * SCL_FREQ_KHZ);
  localparam int         ENABLE_TIME_NS     = 1000;
  localparam int         ENABLE_TIME_CYC    = ENABLE_TIME_NS * (CLK_FREQ_KHZ / 1000) / 1000;
  localparam logic [4:0] TARGET_ADDR_FIXED  = 5'h1a;
  localparam logic [7:0] DISABLE_MASK_RESET = 8'h00;
  localparam logic       DIR_READ           = 1'h1;
  localparam logic [1:0] DIV_BY_1           = 2'h0;
  localparam logic [1:0] DIV_BY_2           = 2'h1;
  localparam logic [1:0] DIV_BY_4           = 2'h2;
  localparam logic [1:0] DIV_BY_8           = 2'h3;
  localparam int         FRAME_BITS         = 18;
  localparam logic [4:0] ADDR_ACK_IDX       = 5'h08;
  localparam logic [4:0] LAST_IDX           = 5'h11;
  localparam logic [3:0] REG_CTRL           = 4'h0;
  localparam logic [3:0] REG_TARGET         = 4'h4;
  localparam logic [3:0] REG_TXDATA         = 4'h8;
  localparam logic [3:0] REG_STATUS         = 4'hc;
  localparam int         CTRL_GO_BIT        = 0;
  localparam int         CTRL_READ_BIT      = 1;
  localparam int         STAT_BUSY_BIT      = 0;
  localparam int         STAT_NACK_BIT      = 1;
  localparam int         STAT_RX_LSB        = 8;
endpackage

// ===== rtl/cdf_target.sv
// Purpose: Reference clock divider with eight gated output pairs and a serial-bus disable mask.
// Assumes: The reference, selects, straps and bus lines are all asynchronous to clk.
// Notes:   Outputs float (enable low) where a mask bit is set; the mask loads at stop.
`timescale 1ns/1ps
module cdf_target #(
  parameter int NUM_OUT = cdf_pkg::NUM_OUTPUTS
) (
  // System
  input  wire logic               clk,
  input  wire logic               rst_n,
  // Reference clock pair
  input  wire logic               ref_clock_true,
  input  wire logic               ref_clock_comp,
  // Straps and selects
  input  wire logic               divider_select_hi,
  input  wire logic               divider_select_lo,
  input  wire logic               addr_strap_hi,
  input  wire logic               addr_strap_lo,
  // Output pairs
  output logic      [NUM_OUT-1:0] clock_output_pair_p,
  output logic      [NUM_OUT-1:0] clock_output_pair_n,
  output logic      [NUM_OUT-1:0] clock_output_pair_oe,
  output logic      [7:0]         output_disable_mask,
  // Serial bus
  cdf_bus_if.target               bus
);
  typedef enum logic [2:0] {
    T_IDLE, T_ADDR, T_ADDR_ACK, T_WRITE, T_WRITE_ACK, T_READ, T_READ_ACK, T_IGNORE
  } cdf_tgt_state_type;

  // Front end: synchronisers, edge history, divider and output pins.
  logic [7:0]         s1_q, s2_q;
  logic [2:0]         prev_q, prev_d;
  logic [2:0]         div_q, div_d;
  logic [NUM_OUT-1:0] p_q, p_d, n_q, n_d, oe_q, oe_d;
  logic               scl, sda, ref_lvl, tap;
  logic [1:0]         sel;
  logic [6:0]         my_addr;
  logic               start, stop, scl_rise, scl_fall;

  // Serial target state.
  cdf_tgt_state_type  st_q, st_d;
  logic [3:0]         bits_q, bits_d;
  logic [7:0]         shift_q, shift_d;
  logic [7:0]         stage_q, stage_d;
  logic               staged_q, staged_d;
  logic               rw_q, rw_d;
  logic               mack_q, mack_d;
  logic               sda_oe_q, sda_oe_d;
  logic [7:0]         mask_q, mask_d;

  assign scl      = s2_q[7];
  assign sda      = s2_q[6];
  assign ref_lvl  = s2_q[5] & ~s2_q[4];
  assign sel      = s2_q[3:2];
  assign my_addr  = {cdf_pkg::TARGET_ADDR_FIXED, s2_q[1], s2_q[0]};
  assign scl_rise = scl & ~prev_q[2];
  assign scl_fall = ~scl & prev_q[2];
  assign start    = scl & prev_q[2] & ~sda & prev_q[1];
  assign stop     = scl & prev_q[2] & sda & ~prev_q[1];

  assign clock_output_pair_p  = p_q;
  assign clock_output_pair_n  = n_q;
  assign clock_output_pair_oe = oe_q;
  assign output_disable_mask  = mask_q;
  assign bus.sda_dev_o        = 1'b0;
  assign bus.sda_dev_oe       = sda_oe_q;

  always_comb begin
    prev_d = {scl, sda, ref_lvl};
    // The divider runs off reference edges only; mask changes never wait on them.
    div_d  = (ref_lvl & ~prev_q[0]) ? div_q + 3'h1 : div_q;
    unique case (sel)
      cdf_pkg::DIV_BY_1: tap = ref_lvl;
      cdf_pkg::DIV_BY_2: tap = div_q[0];
      cdf_pkg::DIV_BY_4: tap = div_q[1];
      cdf_pkg::DIV_BY_8: tap = div_q[2];
    endcase
    p_d  = {NUM_OUT{tap}};
    n_d  = {NUM_OUT{~tap}};
    oe_d = ~mask_q[NUM_OUT-1:0];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q   <= 8'hc0;
      s2_q   <= 8'hc0;
      prev_q <= 3'h6;
      div_q  <= 3'h0;
      p_q    <= '0;
      n_q    <= '1;
      oe_q   <= '1;
    end else begin
      s1_q   <= {bus.scl, bus.sda, ref_clock_true, ref_clock_comp,
                 divider_select_hi, divider_select_lo, addr_strap_hi, addr_strap_lo};
      s2_q   <= s1_q;
      prev_q <= prev_d;
      div_q  <= div_d;
      p_q    <= p_d;
      n_q    <= n_d;
      oe_q   <= oe_d;
    end
  end

  always_comb begin
    st_d     = st_q;
    bits_d   = bits_q;
    shift_d  = shift_q;
    stage_d  = stage_q;
    staged_d = staged_q;
    rw_d     = rw_q;
    mack_d   = mack_q;
    sda_oe_d = sda_oe_q;
    mask_d   = mask_q;
    if (start) begin
      st_d     = T_ADDR;
      bits_d   = 4'h0;
      sda_oe_d = 1'b0;
    end else if (stop) begin
      st_d     = T_IDLE;
      sda_oe_d = 1'b0;
      // The written byte reaches the outputs a few cycles after stop.
      if (staged_q) begin
        mask_d   = stage_q;
        staged_d = 1'b0;
      end
    end else if (scl_rise) begin
      if (st_q == T_ADDR || st_q == T_WRITE) begin
        shift_d = {shift_q[6:0], sda};
        bits_d  = bits_q + 4'h1;
      end else if (st_q == T_READ) begin
        bits_d = bits_q + 4'h1;
      end else if (st_q == T_READ_ACK) begin
        mack_d = ~sda;
      end
    end else if (scl_fall) begin
      unique case (st_q)
        T_ADDR: begin
          if (bits_q == 4'h8) begin
            if (shift_q[7:1] == my_addr) begin
              st_d     = T_ADDR_ACK;
              rw_d     = shift_q[0];
              sda_oe_d = 1'b1;
            end else begin
              st_d = T_IGNORE;
            end
          end
        end
        T_ADDR_ACK: begin
          bits_d = 4'h0;
          if (rw_q == cdf_pkg::DIR_READ) begin
            st_d     = T_READ;
            shift_d  = mask_q;
            sda_oe_d = ~mask_q[7];
          end else begin
            st_d     = T_WRITE;
            sda_oe_d = 1'b0;
          end
        end
        T_WRITE: begin
          if (bits_q == 4'h8) begin
            st_d     = T_WRITE_ACK;
            stage_d  = shift_q;
            staged_d = 1'b1;
            sda_oe_d = 1'b1;
          end
        end
        T_WRITE_ACK: begin
          st_d     = T_WRITE;
          bits_d   = 4'h0;
          sda_oe_d = 1'b0;
        end
        T_READ: begin
          if (bits_q == 4'h8) begin
            st_d     = T_READ_ACK;
            sda_oe_d = 1'b0;
          end else begin
            shift_d  = {shift_q[6:0], 1'b0};
            sda_oe_d = ~shift_q[6];
          end
        end
        T_READ_ACK: begin
          // A controller acknowledge asks for the byte again; NACK ends the read.
          if (mack_q) begin
            st_d     = T_READ;
            bits_d   = 4'h0;
            shift_d  = mask_q;
            sda_oe_d = ~mask_q[7];
          end else begin
            st_d = T_IGNORE;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q     <= T_IDLE;
      bits_q   <= 4'h0;
      shift_q  <= 8'h00;
      stage_q  <= 8'h00;
      staged_q <= 1'b0;
      rw_q     <= 1'b0;
      mack_q   <= 1'b0;
      sda_oe_q <= 1'b0;
      mask_q   <= cdf_pkg::DISABLE_MASK_RESET;
    end else begin
      st_q     <= st_d;
      bits_q   <= bits_d;
      shift_q  <= shift_d;
      stage_q  <= stage_d;
      staged_q <= staged_d;
      rw_q     <= rw_d;
      mack_q   <= mack_d;
      sda_oe_q <= sda_oe_d;
      mask_q   <= mask_d;
    end
  end
endmodule

// ===== sim/cdf_monitor.sv
// Purpose: Watches the two-wire bus between the controller and the divider target.
// Assumes: Every bus signal changes on clk; the controller does no clock stretching.
// Notes:   The bit index counts SCL rises since the last start condition.
`timescale 1ns/1ps
module cdf_monitor (
  // System
  input wire logic clk,
  input wire logic rst_n,
  // Bus
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_host_o,
  input wire logic sda_host_oe,
  input wire logic sda_dev_o,
  input wire logic sda_dev_oe
);
  logic       scl_q;
  logic       scl_d;
  logic       sda_q;
  logic       sda_d;
  logic [4:0] idx_q;
  logic [4:0] idx_d;
  logic       rd_q;
  logic       rd_d;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  always_comb begin
    scl_d = scl;
    sda_d = sda;
    idx_d = idx_q;
    rd_d  = rd_q;
    if (scl && scl_q && sda_q && !sda) begin
      idx_d = 5'h00;
    end else if (scl && !scl_q) begin
      idx_d = idx_q + 5'h01;
      if (idx_q == 5'h07) begin
        rd_d = sda;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      idx_q <= 5'h00;
      rd_q  <= 1'b0;
    end else begin
      scl_q <= scl_d;
      sda_q <= sda_d;
      idx_q <= idx_d;
      rd_q  <= rd_d;
    end
  end

  property p_dev_hold;
    scl && $past(scl) |-> $stable(sda_dev_oe);
  endproperty
  a_dev_hold: assert property (p_dev_hold)
    else $error("target moved sda in scl high");
  // Between frames the count stands at 0 after reset, 10 after an address NACK and 19 after
  // a full frame, since the stop's own clock rise is counted too.
  property p_host_hold;
    scl && $past(scl) && $changed(sda_host_oe) |->
      idx_q == 5'h00 || idx_q == 5'h0a || idx_q == 5'h13;
  endproperty
  a_host_hold: assert property (p_host_hold)
    else $error("host moved sda in a bit");
  property p_start;
    scl && $past(scl) && $fell(sda) |-> ##[1:100] !scl;
  endproperty
  a_start: assert property (p_start)
    else $error("no clock after start");
  property p_stop;
    scl && $past(scl) && $rose(sda) |-> scl [*8];
  endproperty
  a_stop: assert property (p_stop)
    else $error("clock moved right after stop");
  property p_ack_hold;
    $rose(scl) && sda_dev_oe |-> sda_dev_oe throughout (##[1:100] $fell(scl));
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("target let go too early");
  property p_dev_slot;
    $rose(scl) && sda_dev_oe |-> idx_q == 5'h08 || (!rd_q && idx_q == 5'h11) ||
      (rd_q && idx_q > 5'h08 && idx_q < 5'h11);
  endproperty
  a_dev_slot: assert property (p_dev_slot)
    else $error("target drove a wrong bit");
  property p_host_free;
    $rose(scl) && (idx_q == 5'h08 || (rd_q && idx_q > 5'h08 && idx_q < 5'h11))
      |-> !sda_host_oe && sda_host_o == 1'b0;
  endproperty
  a_host_free: assert property (p_host_free)
    else $error("host drove a target bit");
  property p_nack;
    $rose(scl) && rd_q && idx_q == 5'h11 |-> !sda_host_oe && !sda_dev_oe && sda_dev_o == 1'b0;
  endproperty
  a_nack: assert property (p_nack)
    else $error("read not ended by nack");
endmodule

// ===== sim/testbench.sv
// Purpose: Self-checking bench for the controller and divider target pair.
// Assumes: Reference clock of 16 cycles made here; bus bits of four 16-cycle quarters.
// Notes:   Expectations follow from the selects, straps and masks chosen here.
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin failures++; \
  $display("unexpected at %0t: got %0h exp %0h", $time, a, e); end end
module testbench;
  logic        clk = 1'b0;
  logic        rst_n;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [3:0]  ref_cnt = 4'h0;
  logic        ref_run;
  logic [1:0]  sel;
  logic [1:0]  strap;
  logic [7:0]  p;
  logic [7:0]  n;
  logic [7:0]  oe;
  logic [7:0]  mask;
  logic [7:0]  m;
  logic [31:0] st;
  logic [7:0]  tbl [4] = '{8'hff, 8'h00, 8'h01, 8'h80};
  time         t0;
  int          failures;
  int          cmp_count;
  int          cyc;

  cdf_bus_if bus ();
  cdf_controller #(.QUARTER_CYC(16)) u_cdf_controller (.clk(clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .bus(bus));
  cdf_target u_cdf_target (.clk(clk), .rst_n(rst_n), .ref_clock_true(ref_cnt[3]),
    .ref_clock_comp(~ref_cnt[3]), .divider_select_hi(sel[1]), .divider_select_lo(sel[0]),
    .addr_strap_hi(strap[1]), .addr_strap_lo(strap[0]), .clock_output_pair_p(p),
    .clock_output_pair_n(n), .clock_output_pair_oe(oe), .output_disable_mask(mask),
    .bus(bus));
  cdf_monitor u_cdf_monitor (.clk(clk), .rst_n(rst_n), .scl(bus.scl), .sda(bus.sda),
    .sda_host_o(bus.sda_host_o), .sda_host_oe(bus.sda_host_oe),
    .sda_dev_o(bus.sda_dev_o), .sda_dev_oe(bus.sda_dev_oe));

  always #5 clk = ~clk;

  // The reference may be halted to show that mask loads do not need it.
  always @(posedge clk) begin
    if (ref_run) begin
      ref_cnt <= ref_cnt + 4'h1;
    end
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      failures++;
      end_of_test();
    end
  end

  task automatic av(input logic [3:0] a, input logic w, input logic [31:0] d,
                    output logic [31:0] r);
    @(posedge clk);
    avs_address   <= a;
    avs_write     <= w;
    avs_read      <= ~w;
    avs_writedata <= d;
    // The request stands until the edge that sees waitrequest low; read data are taken there.
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic xfer(input logic [6:0] a, input logic rd, input logic [7:0] d);
    av(cdf_pkg::REG_TARGET, 1'b1, {25'h0, a}, st);
    av(cdf_pkg::REG_TXDATA, 1'b1, {24'h0, d}, st);
    av(cdf_pkg::REG_CTRL, 1'b1, {30'h0, rd, 1'b1}, st);
    do begin
      av(cdf_pkg::REG_STATUS, 1'b0, 32'h0, st);
    end while (st[cdf_pkg::STAT_BUSY_BIT] !== 1'b0);
  endtask

  // Output period in clk cycles for a select code, from the 16-cycle reference.
  function automatic int exp_period(input logic [1:0] s);
    return 16 << s;
  endfunction

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    failures = 0;
    cmp_count = 0;
    cyc = 0;
    rst_n = 1'b0;
    ref_run = 1'b1;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    sel = 2'h0;
    void'($urandom(34));
    strap = 2'($urandom);
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    `CHK(mask, 8'h00)
    `CHK(oe, 8'hff)
    for (int s = 0; s < 4; s++) begin
      @(posedge clk);
      sel <= 2'(s);
      repeat (300) @(posedge clk);
      @(posedge p[0]);
      t0 = $time;
      @(posedge p[0]);
      `CHK(($time - t0) / 10, 64'(exp_period(2'(s))))
      #1;
      `CHK(p, {8{p[0]}})
      `CHK(n, ~p)
    end
    av(4'h2, 1'b0, 32'h0, st);
    `CHK(st, 32'h0)
    for (int i = 0; i < 8; i++) begin
      m = (i < 4) ? tbl[i] : 8'($urandom);
      // Outputs are re-enabled only with the reference halted; step 2 halts it anyway.
      ref_run <= (i != 2) && ((mask & ~m) == 8'h00);
      xfer({5'h1a, strap}, 1'b0, m);
      `CHK(st[cdf_pkg::STAT_NACK_BIT], 1'b0)
      repeat (50) @(posedge clk);
      `CHK(mask, m)
      `CHK(oe, ~m)
      av(cdf_pkg::REG_TXDATA, 1'b0, 32'h0, st);
      `CHK(st, {24'h0, m})
      xfer({5'h1a, strap}, 1'b1, 8'h00);
      `CHK(st[15:8], m)
      av(cdf_pkg::REG_CTRL, 1'b0, 32'h0, st);
      `CHK(st[cdf_pkg::CTRL_READ_BIT], 1'b1)
    end
    ref_run <= 1'b1;
    for (int j = 0; j < 2; j++) begin
      xfer((j == 0) ? {5'h1a, ~strap} : {5'h1b, strap}, 1'b0, 8'h55);
      `CHK(st[cdf_pkg::STAT_NACK_BIT], 1'b1)
      repeat (50) @(posedge clk);
      `CHK(mask, m)
    end
    // A second power-up must clear a mask that software had set.
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    `CHK(mask, 8'h00)
    `CHK(oe, 8'hff)
    end_of_test();
  end
endmodule
